// ---- core/ext_instr_timing.sv ----
// execution timer for extended double-operand and 20-bit address instructions
`timescale 1ns/1ps
`include "xcyc_defs.svh"

module ext_instr_timing
    import xcyc_pkg::*;
#(
    parameter int REP_W = `XT_REP_W
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic START,
    input wire format_e FORMAT,
    input wire src_mode_e SRC_MODE,
    input wire dst_mode_e DST_MODE,
    input wire width_e WIDTH,
    input wire op_class_e OP_CLASS,
    input wire logic [REP_W-1:0] REP_COUNT,
    output logic BUSY,
    output logic DONE,
    output logic ILLEGAL,
    output logic [`XT_CYC_W-1:0] CYCLES,
    output logic [`XT_WORDS_W-1:0] WORDS
);

    // ------------------------------------------------------------
    // lookup of the cycle count and length
    // ------------------------------------------------------------

    // the lookup is purely combinational on the descriptor inputs; they matter
    // only at the edge where START is taken, so nothing here is registered
    // until the sequencer accepts the request
    logic [`XT_CYC_W-1:0] lk_cyc;
    logic [`XT_WORDS_W-1:0] lk_words;
    logic lk_bad;
    logic is_wide;
    logic is_mbc;
    logic is_mas;
    logic is_mov;
    logic is_ind;

    // count depends on format, modes, width and repeat count; the op class trims it and picks the address immediate count
    always_comb begin
        is_wide = (WIDTH == WID_ADDR);
        is_mbc = (OP_CLASS == OP_MOVE) || (OP_CLASS == OP_BIT) || (OP_CLASS == OP_CMP);
        is_mas = (OP_CLASS == OP_MOVE) || (OP_CLASS == OP_ADD) || (OP_CLASS == OP_SUB);
        is_mov = (OP_CLASS == OP_MOVE) || (OP_CLASS == OP_BRANCH);
        is_ind = (SRC_MODE == SRC_IND) || (SRC_MODE == SRC_AINC);
        // defaults cover refused codes; the result is not used when lk_bad is set
        lk_cyc = `XD_RR_CYC;
        lk_words = `XD_RR_WORDS;
        lk_bad = 1'b0;
        if (FORMAT == FMT_EXT_DOUBLE) begin
            unique case (SRC_MODE)
                // register source: plain, repeated, pc or memory destination
                SRC_REG: begin
                    unique case (DST_MODE)
                        DST_REG: begin
                            // a repeat count of n above one gives n executions plus one
                            if (REP_COUNT > REP_W'(1)) begin
                                lk_cyc = `XT_CYC_W'(REP_COUNT) + `XD_REP_EXTRA;
                            end else begin
                                lk_cyc = `XD_RR_CYC;
                            end
                            lk_words = `XD_RR_WORDS;
                        end
                        DST_PC: begin
                            lk_cyc = `XD_RP_CYC;
                            lk_words = `XD_RP_WORDS;
                        end
                        default: begin
                            lk_cyc = is_wide ? `XD_RM_A_CYC : `XD_RM_BW_CYC;
                            lk_words = `XD_RM_WORDS;
                        end
                    endcase
                end
                // indirect and autoincrement sources fetch the operand first
                SRC_IND, SRC_AINC: begin
                    unique case (DST_MODE)
                        DST_REG: begin
                            lk_cyc = is_wide ? `XD_IR_A_CYC : `XD_IR_BW_CYC;
                            lk_words = `XD_IRP_WORDS;
                        end
                        DST_PC: begin
                            lk_cyc = is_wide ? `XD_IP_A_CYC : `XD_IP_BW_CYC;
                            lk_words = `XD_IRP_WORDS;
                        end
                        default: begin
                            lk_cyc = is_wide ? `XD_IM_A_CYC : `XD_IM_BW_CYC;
                            lk_words = `XD_IM_WORDS;
                        end
                    endcase
                end
                // immediate source carries one more word for the constant
                SRC_IMM: begin
                    unique case (DST_MODE)
                        DST_REG: begin
                            lk_cyc = `XD_NR_CYC;
                            lk_words = `XD_NRP_WORDS;
                        end
                        DST_PC: begin
                            lk_cyc = `XD_NP_CYC;
                            lk_words = `XD_NRP_WORDS;
                        end
                        default: begin
                            lk_cyc = is_wide ? `XD_NM_A_CYC : `XD_NM_BW_CYC;
                            lk_words = `XD_NM_WORDS;
                        end
                    endcase
                end
                // indexed, symbolic and absolute sources share one row
                default: begin
                    unique case (DST_MODE)
                        DST_REG: begin
                            lk_cyc = is_wide ? `XD_XR_A_CYC : `XD_XR_BW_CYC;
                            lk_words = `XD_XRP_WORDS;
                        end
                        DST_PC: begin
                            lk_cyc = is_wide ? `XD_XP_A_CYC : `XD_XP_BW_CYC;
                            lk_words = `XD_XRP_WORDS;
                        end
                        default: begin
                            lk_cyc = is_wide ? `XD_XM_A_CYC : `XD_XM_BW_CYC;
                            lk_words = `XD_XM_WORDS;
                        end
                    endcase
                end
            endcase

            // trims follow the base lookup; the repeated form never meets them
            // operations that skip the memory write-back or the pc refill
            if (DST_MODE == DST_MEM && is_mbc) begin
                if (is_wide) begin
                    lk_cyc = lk_cyc - `XD_MEM_A_TRIM;
                end else begin
                    lk_cyc = lk_cyc - `XD_MEM_BW_TRIM;
                end
            end
            if (DST_MODE == DST_PC && is_mas && (SRC_MODE == SRC_IMM || SRC_MODE == SRC_MEM)) begin
                lk_cyc = lk_cyc - `XD_PC_TRIM;
            end

            // an undefined destination code or width is refused
            if (DST_MODE != DST_REG && DST_MODE != DST_PC && DST_MODE != DST_MEM) begin
                lk_bad = 1'b1;
            end
            if (WIDTH != WID_BYTE && WIDTH != WID_WORD && WIDTH != WID_ADDR) begin
                lk_bad = 1'b1;
            end
        end else begin
            // address instructions: only move reaches memory; only move and branch reach indirect sources
            unique case (SRC_MODE)
                // register source: move, branch, compare, add or subtract to register or pc, only move to memory
                SRC_REG: begin
                    unique case (DST_MODE)
                        DST_REG: begin
                            lk_cyc = `XA_RR_CYC;
                            lk_words = `XA_R_WORDS;
                        end
                        DST_PC: begin
                            lk_cyc = `XA_RP_CYC;
                            lk_words = `XA_R_WORDS;
                        end
                        default: begin
                            lk_cyc = `XA_RM_CYC;
                            lk_words = `XA_RM_WORDS;
                            lk_bad = (OP_CLASS != OP_MOVE) || (DST_MODE != DST_MEM);
                        end
                    endcase
                end
                // indirect forms exist only for move and branch
                SRC_IND, SRC_AINC: begin
                    lk_cyc = (DST_MODE == DST_PC) ? `XA_IP_CYC : `XA_IR_CYC;
                    lk_words = `XA_I_WORDS;
                    lk_bad = !is_mov || (DST_MODE != DST_REG && DST_MODE != DST_PC);
                end
                // immediate form: move and branch skip the alu step to a register
                SRC_IMM: begin
                    if (DST_MODE == DST_PC) begin
                        lk_cyc = `XA_NP_CYC;
                    end else begin
                        lk_cyc = is_mov ? `XA_NR_MOV_CYC : `XA_NR_ALU_CYC;
                    end
                    lk_words = `XA_N_WORDS;
                    lk_bad = (DST_MODE != DST_REG && DST_MODE != DST_PC);
                end
                // indexed-type sources exist only for move and branch
                default: begin
                    lk_cyc = (DST_MODE == DST_PC) ? `XA_XP_CYC : `XA_XR_CYC;
                    lk_words = `XA_X_WORDS;
                    lk_bad = !is_mov || (DST_MODE != DST_REG && DST_MODE != DST_PC);
                end
            endcase

            // only register and immediate sources to a register or pc take compare/add/subtract
            if (!is_mov && (OP_CLASS != OP_CMP && OP_CLASS != OP_ADD && OP_CLASS != OP_SUB)) begin
                lk_bad = 1'b1;
            end
            if (is_ind && !is_mov) begin
                lk_bad = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // execution sequencer
    // ------------------------------------------------------------

    // busy stands for exactly the looked-up count; cycles and words stand
    // until the next accepted instruction, so a refusal leaves them alone
    seq_state_e state_ff, nxt_state;
    logic [`XT_CYC_W-1:0] remain_ff, nxt_remain;
    logic busy_ff, nxt_busy;
    logic done_ff, nxt_done;
    logic illegal_ff, nxt_illegal;
    logic [`XT_CYC_W-1:0] cycles_ff, nxt_cycles;
    logic [`XT_WORDS_W-1:0] words_ff, nxt_words;

    // one busy cycle per clock period of the instruction; done marks the last one
    always_comb begin
        nxt_state = state_ff;
        nxt_remain = remain_ff;
        nxt_busy = busy_ff;
        nxt_done = 1'b0;
        nxt_illegal = 1'b0;
        nxt_cycles = cycles_ff;
        nxt_words = words_ff;
        unique case (state_ff)
            // an accepted instruction loads its count; a refused one only pulses
            ST_IDLE: begin
                if (START) begin
                    if (lk_bad) begin
                        nxt_illegal = 1'b1; // refused, nothing runs
                    end else begin
                        nxt_state = ST_RUN;
                        nxt_remain = lk_cyc;
                        nxt_busy = 1'b1;
                        nxt_done = (lk_cyc == `XT_CYC_W'(1));
                        nxt_cycles = lk_cyc;
                        nxt_words = lk_words;
                    end
                end
            end
            // count down; the step before the last one raises done
            ST_RUN: begin
                nxt_remain = remain_ff - `XT_CYC_W'(1);
                nxt_done = (remain_ff == `XT_CYC_W'(2));
                if (remain_ff == `XT_CYC_W'(1)) begin
                    nxt_state = ST_IDLE;
                    nxt_busy = 1'b0;
                end
            end
        endcase
    end

    // sequencer registers
    always_ff @(posedge CLK) begin
        if (RST) begin
            state_ff <= ST_IDLE;
            remain_ff <= '0;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
            illegal_ff <= 1'b0;
            cycles_ff <= '0;
            words_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            remain_ff <= nxt_remain;
            busy_ff <= nxt_busy;
            done_ff <= nxt_done;
            illegal_ff <= nxt_illegal;
            cycles_ff <= nxt_cycles;
            words_ff <= nxt_words;
        end
    end

    // a start seen while busy is dropped with no sign; the issuer must hold it
    // outputs straight from the registers
    assign BUSY = busy_ff;
    assign DONE = done_ff;
    assign ILLEGAL = illegal_ff;
    assign CYCLES = cycles_ff;
    assign WORDS = words_ff;

endmodule

// ---- core/xcyc_defs.svh ----
// cycle counts, instruction lengths and widths for the extended instruction timer
`ifndef XCYC_DEFS_SVH
`define XCYC_DEFS_SVH

// widths of the count and length results and of the repeat count
`define XT_CYC_W 8
`define XT_WORDS_W 3
`define XT_REP_W 5

// extended double-operand, register source
`define XD_RR_CYC 8'h02
`define XD_RR_WORDS 3'h2
`define XD_RP_CYC 8'h04
`define XD_RP_WORDS 3'h2
`define XD_RM_BW_CYC 8'h05
`define XD_RM_A_CYC 8'h07
`define XD_RM_WORDS 3'h3
`define XD_REP_EXTRA 8'h01

// extended double-operand, indirect or autoincrement source
`define XD_IR_BW_CYC 8'h03
`define XD_IR_A_CYC 8'h04
`define XD_IP_BW_CYC 8'h05
`define XD_IP_A_CYC 8'h06
`define XD_IRP_WORDS 3'h2
`define XD_IM_BW_CYC 8'h06
`define XD_IM_A_CYC 8'h09
`define XD_IM_WORDS 3'h3

// extended double-operand, immediate source
`define XD_NR_CYC 8'h03
`define XD_NP_CYC 8'h04
`define XD_NRP_WORDS 3'h3
`define XD_NM_BW_CYC 8'h06
`define XD_NM_A_CYC 8'h08
`define XD_NM_WORDS 3'h4

// extended double-operand, indexed / symbolic / absolute source
`define XD_XR_BW_CYC 8'h04
`define XD_XR_A_CYC 8'h05
`define XD_XP_BW_CYC 8'h06
`define XD_XP_A_CYC 8'h07
`define XD_XRP_WORDS 3'h3
`define XD_XM_BW_CYC 8'h07
`define XD_XM_A_CYC 8'h0a
`define XD_XM_WORDS 3'h4

// shortening for move / bit-test / compare to memory and move / add / subtract to pc from immediate or indexed-type sources
`define XD_MEM_BW_TRIM 8'h01
`define XD_MEM_A_TRIM 8'h02
`define XD_PC_TRIM 8'h01

// 20-bit address instructions
`define XA_RR_CYC 8'h01
`define XA_RP_CYC 8'h03
`define XA_R_WORDS 3'h1
`define XA_RM_CYC 8'h04
`define XA_RM_WORDS 3'h2
`define XA_IR_CYC 8'h03
`define XA_IP_CYC 8'h05
`define XA_I_WORDS 3'h1
`define XA_NR_MOV_CYC 8'h02
`define XA_NR_ALU_CYC 8'h03
`define XA_NP_CYC 8'h03
`define XA_N_WORDS 3'h2
`define XA_XR_CYC 8'h04
`define XA_XP_CYC 8'h06
`define XA_X_WORDS 3'h2

`endif

// ---- core/xcyc_pkg.sv ----
// operand modes, widths, operation classes and sequencer states
package xcyc_pkg;
    typedef enum logic [0:0] {FMT_EXT_DOUBLE = 1'b0, FMT_ADDR = 1'b1} format_e;
    typedef enum logic [2:0] {
        SRC_REG = 3'b000, SRC_IND = 3'b001, SRC_AINC = 3'b010, SRC_IMM = 3'b011, SRC_MEM = 3'b100
    } src_mode_e;
    typedef enum logic [1:0] {DST_REG = 2'b00, DST_PC = 2'b01, DST_MEM = 2'b10} dst_mode_e;
    typedef enum logic [1:0] {WID_BYTE = 2'b00, WID_WORD = 2'b01, WID_ADDR = 2'b10} width_e;
    typedef enum logic [2:0] {
        OP_MOVE = 3'b000, OP_BIT = 3'b001, OP_CMP = 3'b010, OP_ADD = 3'b011,
        OP_SUB = 3'b100, OP_BRANCH = 3'b101, OP_OTHER = 3'b110
    } op_class_e;
    typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_RUN = 1'b1} seq_state_e;
endpackage

// ---- tb/ext_instr_timing_properties.sv ----
// checker for the extended instruction timer ports
`timescale 1ns/1ps
`include "xcyc_defs.svh"
module ext_instr_timing_chk
    import xcyc_pkg::*;
#(
    parameter int REP_W = 5
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic START,
    input wire format_e FORMAT,
    input wire src_mode_e SRC_MODE,
    input wire dst_mode_e DST_MODE,
    input wire width_e WIDTH,
    input wire op_class_e OP_CLASS,
    input wire logic [REP_W-1:0] REP_COUNT,
    input wire logic BUSY,
    input wire logic DONE,
    input wire logic ILLEGAL,
    input wire logic [`XT_CYC_W-1:0] CYCLES,
    input wire logic [`XT_WORDS_W-1:0] WORDS
);
    // ---------------------------------
    // busy cycle counter
    // ---------------------------------
    logic [7:0] run_ff;
    logic [7:0] nxt_run;
    logic rr_ext;
    // counts busy cycles before the current one
    always_comb begin
        nxt_run = BUSY ? run_ff + 8'h01 : 8'h00;
    end
    always_ff @(posedge CLK) begin
        run_ff <= RST ? 8'h00 : nxt_run;
    end
    assign rr_ext = FORMAT == FMT_EXT_DOUBLE && SRC_MODE == SRC_REG && DST_MODE == DST_REG;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    AST_TAKE: assert property (START && !BUSY |=> BUSY != ILLEGAL)
        else $error("request not answered");
    AST_IGNORE: assert property (BUSY && !DONE |=> BUSY && !ILLEGAL)
        else $error("busy ended before done");
    AST_DONE_END: assert property (DONE |-> BUSY ##1 !BUSY && !DONE)
        else $error("done not at last busy cycle");
    AST_LENGTH: assert property (DONE |-> run_ff + 8'h01 == CYCLES)
        else $error("busy length differs from count");
    AST_HOLD: assert property (BUSY && $past(BUSY) |-> $stable(CYCLES) && $stable(WORDS))
        else $error("count changed while busy");
    AST_ILL_CAUSE: assert property (ILLEGAL |-> !BUSY && $past(START && !BUSY))
        else $error("refusal without request");
    AST_RR: assert property ($rose(BUSY) && $past(rr_ext && REP_COUNT < 2)
        |-> CYCLES == 8'h02 && WORDS == 3'h2)
        else $error("register pair count wrong");
    AST_REP: assert property ($rose(BUSY) && $past(rr_ext && REP_COUNT > 1)
        |-> CYCLES == 8'($past(REP_COUNT)) + 8'h01)
        else $error("repeat count wrong");
    AST_ADDR_RR: assert property ($rose(BUSY)
        && $past(FORMAT == FMT_ADDR && SRC_MODE == SRC_REG && DST_MODE == DST_REG)
        |-> CYCLES == 8'h01 && DONE && WORDS == 3'h1)
        else $error("address register pair wrong");
    AST_ADDR_MEM: assert property (START && !BUSY && FORMAT == FMT_ADDR && DST_MODE == DST_MEM
        && OP_CLASS inside {OP_CMP, OP_ADD, OP_SUB} |=> ILLEGAL)
        else $error("address memory write not refused");
endmodule
bind ext_instr_timing ext_instr_timing_chk #(.REP_W(REP_W)) i_ext_instr_timing_chk (
    .CLK(CLK), .RST(RST), .START(START), .FORMAT(FORMAT), .SRC_MODE(SRC_MODE), .DST_MODE(DST_MODE),
    .WIDTH(WIDTH), .OP_CLASS(OP_CLASS), .REP_COUNT(REP_COUNT), .BUSY(BUSY), .DONE(DONE),
    .ILLEGAL(ILLEGAL), .CYCLES(CYCLES), .WORDS(WORDS));

// ---- tb/ext_instr_timing_tb.sv ----
// self-checking bench for the extended instruction timer
`timescale 1ns/1ps
`include "xcyc_defs.svh"
module ext_instr_timing_tb;
    import xcyc_pkg::*;
    logic CLK, RST, go, START, BUSY, DONE, ILLEGAL, prev_busy;
    logic [15:0] desc, held, d;
    logic [`XT_CYC_W-1:0] CYCLES;
    logic [`XT_WORDS_W-1:0] WORDS;
    logic [11:0] expq[$];
    logic [11:0] cur;
    logic [10:0] last_ok;
    int n_fail, n_checks, tick, run;
    localparam int XR[8] = '{2, 3, 3, 4, 2, 4, 3, 5};
    localparam int XP[8] = '{4, 5, 4, 6, 4, 6, 4, 7};
    localparam int XM[8] = '{5, 6, 6, 7, 7, 9, 8, 10};
    localparam int XW[4] = '{2, 2, 3, 3};
    localparam int AR[4] = '{1, 3, 2, 4};
    localparam int AP[4] = '{3, 5, 3, 6};
    localparam int AW[4] = '{1, 1, 2, 2};
    instr_issue i_instr_issue (.CLK(CLK), .RST(RST), .BUSY(BUSY), .go(go), .desc(desc), .START(START), .held(held));
    ext_instr_timing #(.REP_W(5)) i_ext_instr_timing (.CLK(CLK), .RST(RST), .START(START),
        .FORMAT(format_e'(held[15])), .SRC_MODE(src_mode_e'(held[14:12])), .DST_MODE(dst_mode_e'(held[11:10])),
        .WIDTH(width_e'(held[9:8])), .OP_CLASS(op_class_e'(held[7:5])), .REP_COUNT(held[4:0]),
        .BUSY(BUSY), .DONE(DONE), .ILLEGAL(ILLEGAL), .CYCLES(CYCLES), .WORDS(WORDS));
    // ---------------------------------
    // expected answer: {refused, cycles, words}
    // ---------------------------------
    function automatic logic [11:0] expect_of(input logic [15:0] d);
        int g, c, w, a, mv;
        g = d[14:12] inside {SRC_IND, SRC_AINC} ? 1 : d[14:12] == SRC_IMM ? 2 : d[14:12] == SRC_MEM ? 3 : 0;
        a = d[9:8] == WID_ADDR ? 4 : 0;
        mv = d[7:5] inside {OP_MOVE, OP_BRANCH};
        if (d[11:10] == 2'h3 || (!d[15] && d[9:8] == 2'h3)) return 12'h800;
        if (!d[15]) begin
            c = d[11:10] == DST_REG ? XR[a + g] :
                d[11:10] == DST_PC ? XP[a + g] : XM[a + g];
            w = XW[g] + (d[11:10] == DST_MEM);
            if (d[11:10] == DST_MEM && d[7:5] inside {OP_MOVE, OP_BIT, OP_CMP}) c -= a ? 2 : 1;
            if (d[11:10] == DST_PC && g >= 2 && d[7:5] inside {OP_MOVE, OP_ADD, OP_SUB}) c -= 1;
            if (d[11:10] == DST_REG && g == 0 && d[4:0] > 1) c = d[4:0] + 1;
        end else begin
            if (!mv && (!(d[7:5] inside {OP_CMP, OP_ADD, OP_SUB}) || g[0])) return 12'h800;
            if (d[11:10] == DST_MEM && (g != 0 || d[7:5] != OP_MOVE)) return 12'h800;
            c = d[11:10] == DST_REG ? AR[g] + (g == 2 && !mv) :
                d[11:10] == DST_PC ? AP[g] : 4;
            w = d[11:10] == DST_MEM ? 2 : AW[g];
        end
        return {1'b0, 8'(c), 3'(w)};
    endfunction
    task automatic check(input logic [11:0] seen, input logic [11:0] want);
        n_checks++;
        if (seen !== want) begin
            n_fail++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge CLK);
            #1;
        end
    endtask
    // hands one instruction to the issuing model and notes its answer
    task automatic issue(input logic [15:0] d);
        int lim;
        lim = 0;
        while (START && lim < 50) begin
            idle(1);
            lim++;
        end
        expq.push_back(expect_of(d));
        desc = d;
        go = 1'b1;
        idle(1);
        go = 1'b0;
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // clock and hang limit
    initial begin
        CLK = 1'b0;
        forever #2 CLK = ~CLK;
    end
    always @(posedge CLK) begin
        tick++;
        if (tick == 20000) begin
            n_fail++;
            complete_run();
        end
    end
    // pairs each answer on the outputs with the oldest note
    always @(posedge CLK) begin
        #1;
        if (RST) last_ok = '0;
        if (!RST && ((BUSY && !prev_busy) || ILLEGAL)) begin
            cur = expq.size() > 0 ? expq.pop_front() : 12'hfff;
            // a refusal leaves the last accepted count and length standing
            if (cur == 12'h800) begin
                cur[10:0] = last_ok;
            end else begin
                last_ok = cur[10:0];
            end
            run = 0;
            check({ILLEGAL, CYCLES, WORDS}, cur);
        end
        if (BUSY) run++;
        if (!RST && DONE) check(12'(run), {4'h0, cur[10:3]});
        prev_busy = BUSY;
    end
    // ---------------------------------
    // main sequence
    // ---------------------------------
    initial begin
        RST = 1'b1;
        go = 1'b0;
        desc = 16'h0000;
        void'($urandom(32'he35e));
        idle(5);
        RST = 1'b0;
        for (int s = 0; s < 5; s++)
            for (int t = 0; t < 4; t++)
                for (int o = 0; o < 7; o++) begin
                    for (int w = 0; w < 4; w++)
                        issue({1'b0, 3'(s), 2'(t), 2'(w), 3'(o), 5'h00});
                    if (t != 2 || s == 0) issue({1'b1, 3'(s), 2'(t), WID_ADDR, 3'(o), 5'h00});
                end
        for (int r = 0; r < 32; r++)
            issue({1'b0, SRC_REG, DST_REG, 2'(r % 3), OP_ADD, 5'(r)});
        repeat (300) begin
            d = 16'($urandom);
            d[14:12] = 3'($urandom % 5);
            d[7:5] = 3'($urandom % 7);
            if (d[15]) d[9:8] = WID_ADDR;
            if (d[15] && d[11:10] == DST_MEM) d[14:12] = SRC_REG;
            idle($urandom % 3);
            issue(d);
        end
        issue({1'b0, SRC_MEM, DST_MEM, WID_ADDR, OP_OTHER, 5'h00});
        idle(4);
        RST = 1'b1;
        idle(2);
        check({BUSY, CYCLES, WORDS}, 12'h000);
        RST = 1'b0;
        issue({1'b1, SRC_IMM, DST_REG, WID_ADDR, OP_CMP, 5'h00});
        idle(20);
        check(12'(expq.size()), 12'h000);
        complete_run();
    end
endmodule

// ---- tb/instr_issue.sv ----
// issuing side model: raises a request and holds it until the timer takes it
`timescale 1ns/1ps
module instr_issue (
    input wire logic CLK,
    input wire logic RST,
    input wire logic BUSY,
    input wire logic go,
    input wire logic [15:0] desc,
    output logic START,
    output logic [15:0] held
);
    // request and descriptor stay put until sampled with busy low
    always_ff @(posedge CLK) begin
        if (RST) begin
            START <= 1'b0;
            held <= 16'h0000;
        end else if (START && !BUSY) begin
            START <= 1'b0;
            held <= ~held; // released fields lose the old value
        end else if (go && !START) begin
            START <= 1'b1;
            held <= desc;
        end
    end
endmodule
